// *** hw/mmie_pkg.sv ***
// shared constants and types for the two-wire bus engine
package mmie_pkg;
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned MIN_DIV        = 20;       // bit rate never above clk/20
   localparam logic [5:0]  FREQ_RST       = 6'h00;
   localparam logic [7:0]  OWN_ADDR_RST   = 8'h00;
   localparam int unsigned SYNC_STAGES    = 2;

   // control bits from software
   typedef struct packed {
      logic       enable;     // module enable
      logic       master;     // 1 requests master mode, 0 -> 1 starts, 1 -> 0 stops
      logic       transmit;   // unused by the engine; bit 0 of the address byte sets direction
      logic       no_ack;     // 1 leaves sda high in ninth clock of received data bytes; a matching slave address is always acked
      logic       rep_start;  // pulse: repeated start while master
   } mmie_ctrl_t;

   // status bits back to software
   typedef struct packed {
      logic       busy;       // bus busy
      logic       is_master;
      logic       addressed;  // own calling address seen
      logic       slave_rd;   // addressed slave must transmit
      logic       arb_lost;
      logic       rx_ack_n;   // ack bit seen in last ninth clock as master (1 = none)
      logic       byte_done;
   } mmie_stat_t;

   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_START = 8'h02,
      ST_BIT   = 8'h04,
      ST_ACK   = 8'h08,
      ST_WAIT  = 8'h10,
      ST_RSTA  = 8'h20,
      ST_STOP  = 8'h40,
      ST_SLAVE = 8'h80
   } mmie_state_t;
endpackage

// *** hw/mmie_sync.sv ***
// two-stage synchroniser for one bus line
`timescale 1ns/1ns
module mmie_sync (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic din,
   output logic      dout
);
   import mmie_pkg::*;
   logic meta_q;
   logic meta_d;
   logic dout_d;

   // lines idle high after reset
   always_comb begin
      meta_d = din;
      dout_d = meta_q;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= 1'b1;
         dout   <= 1'b1;
      end else if (ce) begin
         meta_q <= meta_d;
         dout   <= dout_d;
      end
   end
endmodule

// *** hw/mmie_divider.sv ***
// bit clock divider: decodes the 64 rate settings into a quarter period
`timescale 1ns/1ns
module mmie_divider (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       ce,
   input  wire logic [5:0] freq_sel,
   output logic [10:0]     quarter
);
   import mmie_pkg::*;
   logic [10:0] quarter_d;
   logic [12:0] div;       // largest setting divides by more than 8000

   // divider = tap step times tap index plus base, never under clk/20
   always_comb begin
      div = 13'(MIN_DIV) + ({7'h00, freq_sel} << freq_sel[5:3]);
      quarter_d = div[12:2] + 11'h001;
   end

   always_ff @(posedge clk) begin
      if (srst) quarter <= 11'(MIN_DIV / 4 + 1);
      else if (ce) quarter <= quarter_d;
   end
endmodule

// *** hw/mmie_core.sv ***
// multi-master two-wire bus engine: master and addressed slave
`timescale 1ns/1ns
module mmie_core (
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              ce,
   input  wire mmie_pkg::mmie_ctrl_t ctrl,
   input  wire logic [7:0]        own_address_register,
   input  wire logic [5:0]        freq_sel,
   input  wire logic [7:0]        tx_data,
   input  wire logic              tx_load,
   input  wire logic              flag_clr,
   output mmie_pkg::mmie_stat_t   stat,
   output logic [7:0]             rx_data,
   output logic                   irq_event,
   input  wire logic              scl_i,
   output logic                   scl_o,
   output logic                   scl_oe,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe
);
   import mmie_pkg::*;

   logic        scl_s;
   logic        sda_s;
   logic        scl_p_q;
   logic        sda_p_q;
   logic [10:0] quarter;
   logic        start_det;
   logic        stop_det;
   logic        scl_rise;
   logic        scl_fall;

   mmie_state_t st_q, st_d;
   logic [10:0] cnt_q, cnt_d;
   logic [1:0]  ph_q, ph_d;       // quarter phase within a bit
   logic [3:0]  bit_q, bit_d;     // 0..7 data, 8 then 9 for the slave ack clock (master ack stays at 7 in ST_ACK)
   logic [7:0]  sh_q, sh_d;
   logic        first_q, first_d; // address byte in progress
   logic        dir_rd_q, dir_rd_d;
   logic        drv_sda_q, drv_sda_d;  // 1 pulls sda low
   logic        drv_scl_q, drv_scl_d;  // 1 pulls scl low
   logic        mreq_q;
   logic        busy_q, busy_d;
   logic        mast_q, mast_d;
   logic        adr_q, adr_d;
   logic        srd_q, srd_d;
   logic        arb_q, arb_d;
   logic        nack_q, nack_d;
   logic        done_q, done_d;
   logic        sl_act_q, sl_act_d;  // slave phase: 0 address, 1 data
   logic        sl_on_q, sl_on_d;    // slave tracking a transfer
   logic [7:0]  rx_q, rx_d;
   logic        irq_q, irq_d;

   mmie_sync u_scl_sync (.clk(clk), .srst(srst), .ce(ce), .din(scl_i),
                         .dout(scl_s));
   mmie_sync u_sda_sync (.clk(clk), .srst(srst), .ce(ce), .din(sda_i),
                         .dout(sda_s));
   mmie_divider u_div (.clk(clk), .srst(srst), .ce(ce),
                       .freq_sel(freq_sel), .quarter(quarter));

   // condition and edge detection on synchronised lines
   always_comb begin
      start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
      stop_det  = scl_s && scl_p_q && !sda_p_q && sda_s;
      scl_rise  = scl_s && !scl_p_q;
      scl_fall  = !scl_s && scl_p_q;
   end

   // engine next-state logic
   always_comb begin
      st_d = st_q; cnt_d = cnt_q; ph_d = ph_q; bit_d = bit_q;
      sh_d = sh_q; first_d = first_q; dir_rd_d = dir_rd_q;
      drv_sda_d = drv_sda_q; drv_scl_d = drv_scl_q;
      busy_d = busy_q; mast_d = mast_q; adr_d = adr_q; srd_d = srd_q;
      arb_d = arb_q; nack_d = nack_q; done_d = done_q;
      sl_act_d = sl_act_q; sl_on_d = sl_on_q; rx_d = rx_q; irq_d = 1'b0;

      if (flag_clr) begin
         arb_d = 1'b0; done_d = 1'b0; adr_d = 1'b0;
      end
      if (tx_load) sh_d = tx_data;

      // bus busy follows any start and stop
      if (start_det) busy_d = 1'b1;
      else if (stop_det) busy_d = 1'b0;

      unique case (st_q)
         ST_IDLE: begin
            drv_sda_d = 1'b0; drv_scl_d = 1'b0; mast_d = 1'b0;
            if (ctrl.enable && ctrl.master && !mreq_q && !busy_q
                && scl_s && sda_s) begin
               st_d = ST_START; cnt_d = quarter; mast_d = 1'b1;
               drv_sda_d = 1'b1;
               first_d = 1'b1; bit_d = 4'h0; ph_d = 2'd0;
            end else if (ctrl.enable && start_det) begin
               st_d = ST_SLAVE; sl_on_d = 1'b1; sl_act_d = 1'b0;
               bit_d = 4'h0;
            end
         end
         ST_START, ST_RSTA: begin
            // restart waits until the released scl is really seen high
            if (st_q == ST_RSTA && ph_q == 2'd2 && !scl_s)
               cnt_d = quarter;
            else if (cnt_q > 11'h001) cnt_d = cnt_q - 11'h001;
            else if (st_q == ST_RSTA && ph_q != 2'd3) begin
               // repeated start: release sda, raise scl, then pull sda
               ph_d = ph_q + 2'd1; cnt_d = quarter;
               if (ph_q == 2'd0) drv_sda_d = 1'b0;
               if (ph_q == 2'd1) drv_scl_d = 1'b0;
               if (ph_q == 2'd2) drv_sda_d = 1'b1;
            end else begin
               drv_scl_d = 1'b1; st_d = ST_BIT; ph_d = 2'd0;
               cnt_d = quarter; bit_d = 4'h0; first_d = 1'b1;
            end
         end
         ST_BIT, ST_ACK: begin
            // four quarters per bit: set sda, release scl, sample, pull scl
            if (ph_q == 2'd2 && !scl_s) begin
               cnt_d = quarter;
            end else if (cnt_q > 11'h001) begin
               cnt_d = cnt_q - 11'h001;
            end else begin
               cnt_d = quarter; ph_d = ph_q + 2'd1;
               unique case (ph_q)
                  2'd0: begin
                     if (st_q == ST_BIT)
                        drv_sda_d = (first_q || !dir_rd_q) ? !sh_q[7]
                                                           : 1'b0;
                     else
                        drv_sda_d = (!first_q && dir_rd_q) ? !ctrl.no_ack
                                                           : 1'b0;
                  end
                  2'd1: drv_scl_d = 1'b0;
                  2'd2: begin
                     if (st_q == ST_BIT) begin
                        sh_d = {sh_q[6:0], sda_s};
                        // driving one but seeing zero loses
                        if (!drv_sda_q && !sda_s &&
                            (first_q || !dir_rd_q)) begin
                           arb_d = 1'b1; irq_d = 1'b1;
                           drv_sda_d = 1'b0; drv_scl_d = 1'b0;
                           mast_d = 1'b0; st_d = ST_SLAVE;
                           sl_on_d = 1'b1;
                           sl_act_d = !first_q;
                           bit_d = bit_q + 4'h1;
                        end
                     end else begin
                        nack_d = sda_s;
                     end
                  end
                  2'd3: begin
                     drv_scl_d = 1'b1;
                     if (st_q == ST_BIT && bit_q == 4'h7) begin
                        st_d = ST_ACK; drv_sda_d = 1'b0;
                     end else if (st_q == ST_BIT) begin
                        bit_d = bit_q + 4'h1;
                     end else begin
                        drv_sda_d = 1'b0;
                        if (first_q) dir_rd_d = sh_q[0];
                        rx_d = sh_q; done_d = 1'b1; irq_d = 1'b1;
                        st_d = ST_WAIT;
                     end
                  end
                  default: ;
               endcase
            end
         end
         ST_WAIT: begin
            // hold scl low until software loads data or ends; acked read bytes go on at once
            if (first_q) dir_rd_d = rx_q[0];
            if (!ctrl.master) begin
               st_d = ST_STOP; ph_d = 2'd0; cnt_d = quarter;
               drv_sda_d = 1'b1;
            end else if (ctrl.rep_start) begin
               st_d = ST_RSTA; ph_d = 2'd0; cnt_d = quarter;
            end else if (tx_load ||
                         (!first_q && dir_rd_q && !nack_q)) begin
               first_d = 1'b0; st_d = ST_BIT; bit_d = 4'h0;
               ph_d = 2'd0; cnt_d = quarter;
               if (tx_load) sh_d = tx_data;
            end
         end
         ST_STOP: begin
            // sda rises only once scl is seen high again
            if (ph_q == 2'd1 && !scl_s) cnt_d = quarter;
            else if (cnt_q > 11'h001) cnt_d = cnt_q - 11'h001;
            else begin
               cnt_d = quarter; ph_d = ph_q + 2'd1;
               if (ph_q == 2'd0) drv_scl_d = 1'b0;
               if (ph_q == 2'd1) drv_sda_d = 1'b0;
               if (ph_q == 2'd2) begin
                  st_d = ST_IDLE; mast_d = 1'b0;
               end
            end
         end
         ST_SLAVE: begin
            drv_scl_d = 1'b0;
            if (stop_det || !ctrl.enable) begin
               st_d = ST_IDLE; drv_sda_d = 1'b0; sl_on_d = 1'b0;
               srd_d = 1'b0;
            end else if (start_det) begin
               bit_d = 4'h0; sl_act_d = 1'b0; drv_sda_d = 1'b0;
               sl_on_d = 1'b1;
            end else if (sl_on_q && scl_rise && bit_q < 4'h8) begin
               sh_d = {sh_q[6:0], sda_s};
               bit_d = bit_q + 4'h1;
            end else if (sl_on_q && scl_rise) begin
               if (srd_q && sl_act_q && sda_s)
                  sl_on_d = 1'b0;
               bit_d = 4'h9;
            end else if (sl_on_q && scl_fall && bit_q == 4'h8) begin
               drv_sda_d = 1'b0;
               if (!sl_act_q) begin
                  // address byte compare, own address never sent
                  if (sh_q[7:1] == own_address_register[7:1]) begin
                     drv_sda_d = 1'b1; adr_d = 1'b1; irq_d = 1'b1;
                     srd_d = sh_q[0];
                  end else sl_on_d = 1'b0;
               end else if (!srd_q) begin
                  drv_sda_d = !ctrl.no_ack;
                  rx_d = sh_q; done_d = 1'b1; irq_d = 1'b1;
               end else begin
                  done_d = 1'b1; irq_d = 1'b1;
               end
            end else if (sl_on_q && scl_fall && bit_q == 4'h9) begin
               sl_act_d = 1'b1; bit_d = 4'h0;
               drv_sda_d = srd_q ? !tx_data[7] : 1'b0;
               sh_d = tx_data;
            end else if (sl_on_q && scl_fall && srd_q && sl_act_q
                         && bit_q < 4'h8) begin
               drv_sda_d = !sh_q[7];
            end
         end
         default: st_d = ST_IDLE;
      endcase

      if (!ctrl.enable) begin
         st_d = ST_IDLE; drv_sda_d = 1'b0; drv_scl_d = 1'b0;
         mast_d = 1'b0; sl_on_d = 1'b0;
      end
      // hardware set wins over software clear
      if (irq_d && arb_d) arb_d = 1'b1;
   end

   // state registers
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q      <= ST_IDLE;
         cnt_q     <= 11'h000;
         ph_q      <= 2'd0;
         bit_q     <= 4'h0;
         sh_q      <= 8'h00;
         first_q   <= 1'b0;
         dir_rd_q  <= 1'b0;
         drv_sda_q <= 1'b0;
         drv_scl_q <= 1'b0;
         mreq_q    <= 1'b0;
         busy_q    <= 1'b0;
         mast_q    <= 1'b0;
         adr_q     <= 1'b0;
         srd_q     <= 1'b0;
         arb_q     <= 1'b0;
         nack_q    <= 1'b1;
         done_q    <= 1'b0;
         sl_act_q  <= 1'b0;
         sl_on_q   <= 1'b0;
         rx_q      <= 8'h00;
         irq_q     <= 1'b0;
         // lines idle high, so no false edge follows reset
         scl_p_q   <= 1'b1;
         sda_p_q   <= 1'b1;
      end else if (ce) begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         ph_q      <= ph_d;
         bit_q     <= bit_d;
         sh_q      <= sh_d;
         first_q   <= first_d;
         dir_rd_q  <= dir_rd_d;
         drv_sda_q <= drv_sda_d;
         drv_scl_q <= drv_scl_d;
         mreq_q    <= ctrl.master;
         busy_q    <= busy_d;
         mast_q    <= mast_d;
         adr_q     <= adr_d;
         srd_q     <= srd_d;
         arb_q     <= arb_d;
         nack_q    <= nack_d;
         done_q    <= done_d;
         sl_act_q  <= sl_act_d;
         sl_on_q   <= sl_on_d;
         rx_q      <= rx_d;
         irq_q     <= irq_d;
         scl_p_q   <= scl_s;
         sda_p_q   <= sda_s;
      end
   end

   // open-drain pins and status
   always_comb begin
      sda_o  = 1'b0;
      scl_o  = 1'b0;
      sda_oe = drv_sda_q;
      scl_oe = drv_scl_q;
      rx_data = rx_q;
      irq_event = irq_q;
      stat.busy = busy_q;
      stat.is_master = mast_q;
      stat.addressed = adr_q;
      stat.slave_rd = srd_q;
      stat.arb_lost = arb_q;
      stat.rx_ack_n = nack_q;
      stat.byte_done = done_q;
   end
endmodule

// *** sim/mmie_assertions.sv ***
// port-level assertions for the two-wire bus engine
`timescale 1ns/1ns
module mmie_chk (
   input wire logic                 clk,
   input wire logic                 srst,
   input wire mmie_pkg::mmie_ctrl_t ctrl,
   input wire mmie_pkg::mmie_stat_t stat,
   input wire logic                 irq_event,
   input wire logic                 scl_i,
   input wire logic                 scl_o,
   input wire logic                 scl_oe,
   input wire logic                 sda_i,
   input wire logic                 sda_o,
   input wire logic                 sda_oe
);
   import mmie_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // both lines released and no ack seen once reset ends
   chk_reset_idle: assert property (
      $fell(srst) |-> !sda_oe && !scl_oe && stat.rx_ack_n && !stat.busy)
      else $error("lines driven or flags wrong after reset");
   // open drain: the driven level is always low
   chk_open_drain: assert property (
      !scl_o && !sda_o)
      else $error("bus line driven high");
   // a start on an idle bus pulls sda first, scl still released
   chk_start_first: assert property (
      ctrl.enable && $rose(ctrl.master) && !stat.busy && scl_i && sda_i
      |=> sda_oe && !scl_oe)
      else $error("start not sda low with scl high");
   // any start on the bus sets busy
   chk_busy_set: assert property (
      scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:5] stat.busy)
      else $error("busy not set after start");
   // any stop on the bus clears busy
   chk_busy_clear: assert property (
      scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:5] !stat.busy)
      else $error("busy not cleared after stop");
   // event request lasts a single cycle
   chk_irq_pulse: assert property (
      irq_event |=> !irq_event)
      else $error("event request longer than one cycle");
   // each completed byte comes with an event request
   chk_byte_irq: assert property (
      $rose(stat.byte_done) |-> (irq_event || $past(irq_event))
      or (##1 irq_event))
      else $error("byte done without event request");
   // lost arbitration gives up master role and sda
   chk_arb_slave: assert property (
      $rose(stat.arb_lost) |-> ##[0:3] (!stat.is_master && !sda_oe))
      else $error("master role kept after arbitration loss");
   // sda frozen while another device stretches scl low
   chk_stretch_wait: assert property (
      stat.is_master && !scl_oe && !scl_i && !$past(scl_oe)
      |=> $stable(sda_oe))
      else $error("sda moved while scl stretched");
   // scl low and high phases at least six cycles, one quarter period at the fastest rate
   chk_scl_low: assert property (
      stat.is_master && $rose(scl_oe) |=> scl_oe [*5])
      else $error("scl low phase too short");
   chk_scl_high: assert property (
      stat.is_master && $fell(scl_oe) |=> !scl_oe [*5])
      else $error("scl high phase too short");
endmodule

bind mmie_core mmie_chk mmie_chk_inst (
   .clk(clk), .srst(srst), .ctrl(ctrl), .stat(stat), .irq_event(irq_event),
   .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);

// *** sim/mmie_partner.sv ***
// far-side model: addressed slave with scl stretching and forced sda low
`timescale 1ns/1ns
module mmie_partner #(
   parameter logic [6:0] ADDR = 7'h2A,
   parameter logic [7:0] RD   = 8'h5C
) (
   input  wire logic       clk,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       hold,
   input  wire logic [5:0] stretch,
   output logic            scl_pull,
   output logic            sda_pull,
   output logic [7:0]      got
);
   logic       ps = 1'b1, pd = 1'b1, act = 1'b0, first = 1'b0;
   logic       rd = 1'b0, drv = 1'b0;
   logic [3:0] n = 4'hF;
   logic [7:0] sh = 8'h00;
   logic [5:0] cnt = 6'h00;

   // only ever pull low, release otherwise
   assign sda_pull = drv | hold;
   assign scl_pull = cnt != 6'h00;

   // slave sequencer sampling both lines on the system clock
   always @(posedge clk) begin
      ps <= scl;
      pd <= sda;
      if (cnt != 6'h00) cnt <= cnt - 6'h01;
      if (ps && scl && pd && !sda) begin
         act <= 1'b1;
         first <= 1'b1;
         rd <= 1'b0;
         n <= 4'hF;
         drv <= 1'b0;
      end else if (ps && scl && !pd && sda) begin
         act <= 1'b0;
         drv <= 1'b0;
      end else if (act && !ps && scl) begin
         if (n < 4'h8) sh <= {sh[6:0], sda};
         else if (rd && !first && sda) begin
            act <= 1'b0;
            drv <= 1'b0;
         end
      end else if (act && ps && !scl) begin
         cnt <= stretch;
         n <= (n == 4'h8 || n == 4'hF) ? 4'h0 : n + 4'h1;
         drv <= 1'b0;
         if (n == 4'h7 && first) begin
            if (sh[7:1] == ADDR) begin
               drv <= 1'b1;
               rd <= sh[0];
            end else act <= 1'b0;
         end else if (n == 4'h7 && !rd) begin
            drv <= 1'b1;
            got <= sh;
         end else if (n == 4'h8) begin
            first <= 1'b0;
            drv <= rd & ~RD[7];
         end else if (n < 4'h7) drv <= rd & ~first & ~RD[3'h6 - n[2:0]];
      end
   end
endmodule

// *** sim/mmie_tb.sv ***
// self-checking bench for the two-wire bus engine
`timescale 1ns/1ns
module testbench;
   import mmie_pkg::*;
   localparam logic [6:0] P_ADDR = 7'h2A;
   localparam logic [7:0] P_RD   = 8'h5C;
   logic       clk = 1'b0, srst = 1'b1, tx_load = 1'b0, flag_clr = 1'b0;
   logic       hold = 1'b0, ps = 1'b1, pd = 1'b1, pv = 1'b0;
   logic [7:0] tx_data = 8'h00, rx_data, got;
   logic [5:0] freq_sel = 6'h00, stretch = 6'h00;
   logic       irq_event, scl_o, scl_oe, sda_o, sda_oe, p_scl, p_sda;
   logic       scl, sda;
   mmie_ctrl_t ctrl = '0;
   mmie_stat_t stat;
   int         bad_count = 0, cmp_count = 0, n_sta = 0, n_sto = 0;
   int         cyc = 0, last = 0, per = 0;

   // wired-and lines with pull-ups
   assign scl = ~(scl_oe | p_scl);
   assign sda = ~(sda_oe | p_sda);

   mmie_core mmie_core_inst (
      .clk(clk), .srst(srst), .ce(1'b1), .ctrl(ctrl),
      .own_address_register(8'h44), .freq_sel(freq_sel),
      .tx_data(tx_data), .tx_load(tx_load), .flag_clr(flag_clr),
      .stat(stat), .rx_data(rx_data), .irq_event(irq_event),
      .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe)
   );
   mmie_partner #(.ADDR(P_ADDR), .RD(P_RD)) mmie_partner_inst (
      .clk(clk), .scl(scl), .sda(sda), .hold(hold), .stretch(stretch),
      .scl_pull(p_scl), .sda_pull(p_sda), .got(got)
   );

   always #25 clk = ~clk;

   // bus start and stop counts, period of the engine's own scl
   always @(posedge clk) begin
      ps <= scl;
      pd <= sda;
      pv <= scl_oe;
      cyc <= cyc + 1;
      if (ps && scl && pd && !sda) n_sta <= n_sta + 1;
      if (ps && scl && !pd && sda) n_sto <= n_sto + 1;
      if (scl_oe && !pv) begin
         per <= cyc - last;
         last <= cyc;
      end
   end

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #5;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic bit cond(input int k);
      case (k)
         0: return stat.byte_done === 1'b1;
         1: return stat.busy === 1'b0;
         2: return stat.arb_lost === 1'b1;
         3: return scl === 1'b0;
         default: return stat.is_master === 1'b0;
      endcase
   endfunction
   // bounded wait on a completion condition
   task automatic wt(input int k);
      for (int i = 0; i < 20000 && !cond(k); i++) tick(1);
      if (!cond(k)) chk("wait", 16'h0000, 16'h0001);
   endtask
   task automatic load(input logic [7:0] d);
      tx_data = d;
      tx_load = 1'b1;
      tick(1);
      tx_load = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] a);
      load(a);
      ctrl.master = 1'b1;
      tick(1);
   endtask
   // repeated start from the wait state with a new address byte
   task automatic restart(input logic [7:0] a);
      tx_data = a;
      tx_load = 1'b1;
      ctrl.rep_start = 1'b1;
      tick(1);
      tx_load = 1'b0;
      ctrl.rep_start = 1'b0;
   endtask
   task automatic byte_wait;
      wt(0);
      flag_clr = 1'b1;
      tick(1);
      flag_clr = 1'b0;
   endtask
   task automatic stop_bus;
      ctrl.master = 1'b0;
      // engine must be back in idle before the next start is asked for
      wt(1);
      wt(4);
      tick(2);
   endtask
   // last bit period against the divider of the current setting
   task automatic rate;
      int d;
      d = 20 + (int'(freq_sel) << freq_sel[5:3]);
      chk("period", 16'(per >= d && per < d + 16), 16'h0001);
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // main sequence
   initial begin
      tick(20);
      srst = 1'b0;
      tick(3);
      chk("busy", stat.busy, 1'b0);
      chk("sda_oe", {scl_oe, sda_oe}, 2'b00);
      ctrl.enable = 1'b1;
      ctrl.transmit = 1'b1;
      xfer({P_ADDR, 1'b0});
      byte_wait();
      chk("addr ack", stat.rx_ack_n, 1'b0);
      chk("master", {stat.is_master, stat.busy}, 2'b11);
      rate();
      load(8'hA5);
      byte_wait();
      chk("written", got, 8'hA5);
      restart({P_ADDR, 1'b0});
      byte_wait();
      chk("restart", {n_sta[7:0], n_sto[7:0]}, 16'h0200);
      stop_bus();
      freq_sel = 6'h12;
      ctrl.transmit = 1'b0;
      xfer({P_ADDR, 1'b1});
      byte_wait();
      rate();
      ctrl.no_ack = 1'b1;
      load(8'h00);
      byte_wait();
      chk("read", rx_data, P_RD);
      chk("master nack", stat.rx_ack_n, 1'b1);
      stop_bus();
      ctrl.no_ack = 1'b0;
      freq_sel = 6'h00;
      stretch = 6'h30;
      ctrl.transmit = 1'b1;
      xfer(8'hAA);
      byte_wait();
      chk("no ack", stat.rx_ack_n, 1'b1);
      chk("stretch", 16'(per > int'(stretch)), 16'h0001);
      stop_bus();
      stretch = 6'h00;
      xfer(8'hFE);
      wt(3);
      hold = 1'b1;
      wt(2);
      chk("lost", {stat.is_master, sda_oe}, 2'b00);
      ctrl.master = 1'b0;
      tick(2);
      hold = 1'b0;
      wt(1);
      chk("starts", n_sta, 16'd5);
      chk("stops", n_sto, 16'd4);
      tally_and_finish();
   end

   // watchdog: the sequence needs a few thousand cycles
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
endmodule
